// ---- core/sfs_pkg.sv ----
// Purpose: Shared constants and types for the sector flash sequencer
// Assumes: 50 MHz mclk, byte-wide flash array port with one-cycle read latency
// Notes:   Geometry and timing counts live here; long counts are overridable at the top
package sfs_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W          = 19;              // Flash offset width in bytes
	localparam int unsigned LEN_W           = 20;              // Length width, holds a full memory
	localparam int unsigned SECTOR_SHIFT    = 15;              // 32 Kbyte sectors
	localparam int unsigned SECTOR_W        = ADDR_W - SECTOR_SHIFT;
	localparam int unsigned SECTOR_KBYTES   = 32;
	localparam logic [SECTOR_W-1:0] SECTOR_COUNT = 4'hF;       // Highest sector index, 16 sectors
	localparam logic [LEN_W-1:0]    MEM_BYTES    = 20'h80000;  // Total bytes of the array
	localparam int unsigned PW_BYTES        = 16;              // Pageword size
	localparam logic [3:0]  PW_LAST         = 4'hF;            // Offset of last byte of a pageword
	localparam logic [3:0]  PW_ALIGN        = 4'h0;            // Required start offset in a pageword
	localparam int unsigned PW_PER_SECTOR   = SECTOR_KBYTES * 1024 / PW_BYTES;
	localparam logic [7:0]  BLANK_BYTE      = 8'hFF;           // Erased contents

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ            = 50;
	localparam int unsigned ERASE_TIME_MS      = 100;
	localparam int unsigned PROG_SECTOR_US     = 1000;
	localparam int unsigned ERASE_CYCLES_DEF   = ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned PROG_SECTOR_CYCLES_DEF = PROG_SECTOR_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0]       TIMER_RST = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RST  = 19'h00000;
	localparam logic [LEN_W-1:0]  LEN_RST   = 20'h00000;
	localparam logic [7:0]        BYTE_RST  = 8'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NOP     = 3'h0,
		OP_READ    = 3'h1,
		OP_PROGRAM = 3'h2,
		OP_ERASE   = 3'h3,
		OP_SELECT  = 3'h4,
		OP_SLEEP   = 3'h5,
		OP_WAKE    = 3'h6
	} sfs_op_t;

	typedef enum logic [2:0] {
		S_IDLE     = 3'b000,
		S_RD_ISSUE = 3'b001,
		S_RD_DATA  = 3'b011,
		S_PG_WAIT  = 3'b010,
		S_PG_READ  = 3'b110,
		S_PG_WRITE = 3'b111,
		S_PG_HOLD  = 3'b101,
		S_ERASE    = 3'b100
	} sfs_state_t;

	typedef struct packed {
		logic              valid;
		sfs_op_t           op;
		logic [ADDR_W-1:0] addr;
		logic [LEN_W-1:0]  len;
		logic              ext;
		logic              ext_supported;
	} sfs_req_t;

	typedef struct packed {
		logic              re;
		logic              we;
		logic              erase;
		logic              ext;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} sfs_arr_t;

	localparam sfs_arr_t ARR_RST = '{re: 1'b0, we: 1'b0, erase: 1'b0, ext: 1'b0,
		addr: 19'h00000, wdata: 8'hFF};

endpackage

// ---- core/sfs_sector_flash_sequencer.sv ----
// Purpose: Sequencer for erase, read and pageword programming of sectored flash
// Assumes: Array answers a read one cycle after re; erase wipes the sector to ones
// Notes:   Host ops arrive as one struct; program bytes stream in on a valid/ready pair
module sfs_sector_flash_sequencer #(
	parameter int unsigned ERASE_CYCLES       = sfs_pkg::ERASE_CYCLES_DEF,
	parameter int unsigned PROG_SECTOR_CYCLES = sfs_pkg::PROG_SECTOR_CYCLES_DEF
) (
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire sfs_pkg::sfs_req_t req,
	output logic                  req_ready,
	output logic                  busy,
	output logic                  done,
	output logic                  reject,
	input  wire logic             wr_valid,
	input  wire logic [7:0]       wr_data,
	output logic                  wr_ready,
	output logic                  rd_valid,
	output logic [7:0]            rd_data,
	input  wire logic             flash_error_irq_enable,
	output logic                  flash_error_irq,
	output logic                  ext_selected,
	output logic                  ext_flash_sleep_cmd,
	output logic                  ext_flash_wake_cmd,
	output sfs_pkg::sfs_arr_t     arr,
	input  wire logic [7:0]       array_rdata,
	input  wire logic             array_rd_err
);
	import sfs_pkg::*;

	// ----------------------------------------------------------------
	// Derived hold times
	// ----------------------------------------------------------------
	localparam int unsigned PW_HOLD_RAW = PROG_SECTOR_CYCLES / PW_PER_SECTOR;
	localparam int unsigned PW_HOLD     = (PW_HOLD_RAW < 1) ? 1 : PW_HOLD_RAW;
	localparam int unsigned ERASE_HOLD  = (ERASE_CYCLES < 1) ? 1 : ERASE_CYCLES;
	localparam logic [31:0] PW_LOAD     = 32'(PW_HOLD - 1);
	localparam logic [31:0] ERASE_LOAD  = 32'(ERASE_HOLD - 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	sfs_state_t        state;
	sfs_state_t        next_state;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic [LEN_W-1:0]  remain;
	logic [LEN_W-1:0]  next_remain;
	logic [31:0]       timer;
	logic [31:0]       next_timer;
	logic [7:0]        byte_hold;
	logic [7:0]        next_byte_hold;
	logic              ext_supported;
	logic              next_ext_supported;
	logic              next_ext_selected;
	sfs_arr_t          next_arr;
	logic              next_req_ready;
	logic              next_busy;
	logic              next_done;
	logic              next_reject;
	logic              next_wr_ready;
	logic              next_rd_valid;
	logic [7:0]        next_rd_data;
	logic              next_irq;
	logic              next_sleep;
	logic              next_wake;

	// Request checks
	logic [LEN_W-1:0]   req_end;
	logic               in_range;
	logic               aligned;
	logic [SECTOR_W-1:0] req_sector;
	logic [ADDR_W-1:0]  addr_inc;

	// Range and alignment of the incoming request
	always_comb begin
		req_end    = LEN_W'({1'b0, req.addr}) + req.len;
		in_range   = (req.len <= MEM_BYTES) && (req_end <= MEM_BYTES); // Huge lengths cannot wrap the sum
		aligned    = (req.addr[3:0] == PW_ALIGN) && (req.len[3:0] == PW_ALIGN);
		req_sector = req.addr[ADDR_W-1:SECTOR_SHIFT];
		addr_inc   = addr + ADDR_W'(1);
	end

	// ----------------------------------------------------------------
	// Sequencer next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_state         = state;
		next_addr          = addr;
		next_remain        = remain;
		next_timer         = timer;
		next_byte_hold     = byte_hold;
		next_ext_selected  = ext_selected;
		next_ext_supported = ext_supported;
		next_arr           = arr;
		next_arr.re        = 1'b0;
		next_arr.we        = 1'b0;
		next_arr.erase     = 1'b0;
		next_req_ready     = 1'b0;
		next_busy          = 1'b1;
		next_done          = 1'b0;
		next_reject        = 1'b0;
		next_wr_ready      = 1'b0;
		next_rd_valid      = 1'b0;
		next_rd_data       = rd_data;
		next_irq           = 1'b0;
		next_sleep         = 1'b0;
		next_wake          = 1'b0;
		case (state)
			S_IDLE: begin
				// Only idle takes requests; elsewhere ready stays low
				next_busy      = 1'b0;
				next_req_ready = 1'b1;
				if (req.valid && req_ready) begin
					case (req.op)
						OP_READ: begin
							if (!in_range) begin
								next_reject = 1'b1;
							end else if (req.len == LEN_RST) begin
								next_done = 1'b1;
							end else begin
								// Any byte offset may start a read
								next_addr      = req.addr;
								next_remain    = req.len;
								next_arr.re    = 1'b1;
								next_arr.addr  = req.addr;
								next_req_ready = 1'b0;
								next_busy      = 1'b1;
								next_state     = S_RD_ISSUE;
							end
						end
						OP_PROGRAM: begin
							if (!in_range || !aligned) begin
								next_reject = 1'b1;
							end else if (req.len == LEN_RST) begin
								next_done = 1'b1;
							end else begin
								next_addr      = req.addr;
								next_remain    = req.len;
								next_wr_ready  = 1'b1;
								next_req_ready = 1'b0;
								next_busy      = 1'b1;
								next_state     = S_PG_WAIT;
							end
						end
						OP_ERASE: begin
							if (req_sector > SECTOR_COUNT) begin
								next_reject = 1'b1;
							end else begin
								// Whole sector, sector zero included
								next_arr.erase = 1'b1;
								next_arr.addr  = {req_sector, {SECTOR_SHIFT{1'b0}}};
								next_timer     = ERASE_LOAD;
								next_req_ready = 1'b0;
								next_busy      = 1'b1;
								next_state     = S_ERASE;
							end
						end
						OP_SELECT: begin
							next_ext_selected  = req.ext;
							next_ext_supported = req.ext && req.ext_supported;
							next_done          = 1'b1;
						end
						OP_SLEEP: begin
							// Dropped silently for on-chip or unsupported parts
							next_sleep = ext_selected && ext_supported;
							next_done  = 1'b1;
						end
						OP_WAKE: begin
							next_wake = ext_selected && ext_supported;
							next_done = 1'b1;
						end
						default: begin
							next_reject = 1'b1;
						end
					endcase
				end
			end
			S_RD_ISSUE: begin
				// Array sees the strobe now; data follows next cycle
				next_state = S_RD_DATA;
			end
			S_RD_DATA: begin
				next_rd_valid = 1'b1;
				next_rd_data  = array_rdata;
				next_irq      = array_rd_err && flash_error_irq_enable;
				next_remain   = remain - LEN_W'(1);
				next_addr     = addr_inc;
				if (remain == LEN_W'(1)) begin
					next_done      = 1'b1;
					next_busy      = 1'b0;
					next_req_ready = 1'b1;
					next_state     = S_IDLE;
				end else begin
					next_arr.re   = 1'b1;
					next_arr.addr = addr_inc;
					next_state    = S_RD_ISSUE;
				end
			end
			S_PG_WAIT: begin
				next_wr_ready = 1'b1;
				if (wr_valid && wr_ready) begin
					next_wr_ready  = 1'b0;
					next_byte_hold = wr_data;
					next_arr.re    = 1'b1;
					next_arr.addr  = addr;
					next_state     = S_PG_READ;
				end
			end
			S_PG_READ: begin
				next_state = S_PG_WRITE;
			end
			S_PG_WRITE: begin
				// Merge with current contents so no zero returns to one
				next_arr.we    = 1'b1;
				next_arr.addr  = addr;
				next_arr.wdata = array_rdata & byte_hold;
				next_remain    = remain - LEN_W'(1);
				next_addr      = addr_inc;
				if (addr[3:0] == PW_LAST) begin
					next_timer = PW_LOAD;
					next_state = S_PG_HOLD;
				end else begin
					next_wr_ready = 1'b1;
					next_state    = S_PG_WAIT;
				end
			end
			S_PG_HOLD: begin
				// Pageword program time, a share of the sector time
				if (timer == TIMER_RST) begin
					if (remain == LEN_RST) begin
						next_done      = 1'b1;
						next_busy      = 1'b0;
						next_req_ready = 1'b1;
						next_state     = S_IDLE;
					end else begin
						next_wr_ready = 1'b1;
						next_state    = S_PG_WAIT;
					end
				end else begin
					next_timer = timer - 32'h0000_0001;
				end
			end
			S_ERASE: begin
				// Busy for the full erase time
				if (timer == TIMER_RST) begin
					next_done      = 1'b1;
					next_busy      = 1'b0;
					next_req_ready = 1'b1;
					next_state     = S_IDLE;
				end else begin
					next_timer = timer - 32'h0000_0001;
				end
			end
			default: begin
				next_busy      = 1'b0;
				next_req_ready = 1'b1;
				next_state     = S_IDLE;
			end
		endcase
		next_arr.ext = next_ext_selected;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state               <= S_IDLE;
			addr                <= ADDR_RST;
			remain              <= LEN_RST;
			timer               <= TIMER_RST;
			byte_hold           <= BYTE_RST;
			ext_selected        <= 1'b0;
			ext_supported       <= 1'b0;
			arr                 <= ARR_RST;
			req_ready           <= 1'b0;
			busy                <= 1'b1;
			done                <= 1'b0;
			reject              <= 1'b0;
			wr_ready            <= 1'b0;
			rd_valid            <= 1'b0;
			rd_data             <= BYTE_RST;
			flash_error_irq     <= 1'b0;
			ext_flash_sleep_cmd <= 1'b0;
			ext_flash_wake_cmd  <= 1'b0;
		end else begin
			state               <= next_state;
			addr                <= next_addr;
			remain              <= next_remain;
			timer               <= next_timer;
			byte_hold           <= next_byte_hold;
			ext_selected        <= next_ext_selected;
			ext_supported       <= next_ext_supported;
			arr                 <= next_arr;
			req_ready           <= next_req_ready;
			busy                <= next_busy;
			done                <= next_done;
			reject              <= next_reject;
			wr_ready            <= next_wr_ready;
			rd_valid            <= next_rd_valid;
			rd_data             <= next_rd_data;
			flash_error_irq     <= next_irq;
			ext_flash_sleep_cmd <= next_sleep;
			ext_flash_wake_cmd  <= next_wake;
		end
	end

endmodule

// ---- sim/sfs_seq_properties.sv ----
// Purpose: Port-level checks on the sector flash sequencer
// Assumes: Bench runs with a short erase count
// Notes:   Bound into every sequencer instance
module sfs_seq_properties #(
	parameter int ERASE_CYCLES = 20
) (
	input wire logic              mclk,
	input wire logic              resetn,
	input wire sfs_pkg::sfs_req_t req,
	input wire logic              req_ready,
	input wire logic              busy,
	input wire logic              done,
	input wire logic              reject,
	input wire logic              rd_valid,
	input wire logic              flash_error_irq_enable,
	input wire logic              flash_error_irq,
	input wire logic              ext_selected,
	input wire logic              ext_flash_sleep_cmd,
	input wire logic              ext_flash_wake_cmd,
	input wire sfs_pkg::sfs_arr_t arr,
	input wire logic [7:0]        array_rdata,
	input wire logic              array_rd_err
);
	timeunit 1ns;
	timeprecision 1ps;
	import sfs_pkg::*;
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_ready_only_idle: assert property (req_ready |-> !busy)
		else $error("ready while busy");
	a_take_goes_busy: assert property (
		req.valid && req_ready && req.op == OP_ERASE |=> busy && !req_ready)
		else $error("erase taken but not busy");
	a_misalign_reject: assert property (
		req.valid && req_ready && req.op == OP_PROGRAM && (req.addr[3:0] != 4'h0 || req.len[3:0] != 4'h0) |=> reject)
		else $error("misaligned program not refused");
	a_erase_sector_base: assert property (arr.erase |-> arr.addr[14:0] == 15'h0000)
		else $error("erase not at sector base");
	a_erase_stays_busy: assert property (arr.erase |=> (busy && !done) [*8])
		else $error("erase ended early");
	a_erase_done_time: assert property (arr.erase |-> ##ERASE_CYCLES done)
		else $error("erase done at wrong time");
	a_prog_only_clears: assert property (arr.we |-> (arr.wdata & ~$past(array_rdata)) == 8'h00)
		else $error("program set a bit");
	a_irq_on_bad_read: assert property (
		rd_valid && $past(array_rd_err) && $past(flash_error_irq_enable) |-> flash_error_irq)
		else $error("bad read without interrupt");
	a_irq_gated: assert property (flash_error_irq |-> rd_valid && $past(flash_error_irq_enable))
		else $error("interrupt without enable");
	a_pwr_ext_only: assert property (ext_flash_sleep_cmd || ext_flash_wake_cmd |-> ext_selected)
		else $error("power command on chip flash");
	c_erase: cover property (arr.erase);
	c_write: cover property (arr.we);
	c_irq: cover property (flash_error_irq);
	c_read: cover property (rd_valid);
	c_sleep: cover property (ext_flash_sleep_cmd);
endmodule

bind sfs_sector_flash_sequencer sfs_seq_properties #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (.mclk, .resetn, .req,
	.req_ready, .busy, .done, .reject, .rd_valid, .flash_error_irq_enable, .flash_error_irq, .ext_selected,
	.ext_flash_sleep_cmd, .ext_flash_wake_cmd, .arr, .array_rdata, .array_rd_err);

// ---- sim/sfs_array_model.sv ----
// Purpose: Behavioural flash array answering the sequencer
// Assumes: One-cycle read latency, 32 Kbyte sectors
// Notes:   Read error flag raised only while the bench asks for it
module sfs_array_model (
	input  wire logic              mclk,
	input  wire sfs_pkg::sfs_arr_t arr,
	input  wire logic              bad,
	output logic [7:0]             array_rdata,
	output logic                   array_rd_err
);
	timeunit 1ns;
	timeprecision 1ps;
	import sfs_pkg::*;
	logic [7:0] mem [int];
	initial begin
		array_rdata = 8'h00;
		array_rd_err = 1'b0;
	end
	// Array access; unwritten bytes read blank, idle data toggles
	always @(posedge mclk) begin
		array_rd_err <= arr.re & bad;
		if (arr.re)
			array_rdata <= mem.exists(int'(arr.addr)) ? mem[int'(arr.addr)] : BLANK_BYTE;
		else
			array_rdata <= ~array_rdata;
		if (arr.we)
			mem[int'(arr.addr)] = arr.wdata;
		if (arr.erase)
			for (int i = 0; i < 32768; i++)
				mem.delete(int'({arr.addr[18:15], i[14:0]}));
	end
endmodule

// ---- sim/tb_sector_flash_sequencer.sv ----
// Purpose: Self-checking bench for the sector flash sequencer
// Assumes: Short erase and program counts
// Notes:   Partner array model answers all accesses
module tb_sector_flash_sequencer import sfs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ERASE_N = 20;
	localparam int PROG_N  = 4096;  // Two-cycle pageword hold
	logic       mclk, resetn, wr_valid, wr_ready, irq_en, irq, bad, ext_sel, slp, wak;
	logic       req_ready, busy, done, reject, rd_valid, array_rd_err;
	logic [7:0] wr_data, rd_data, array_rdata;
	sfs_req_t   req;
	sfs_arr_t   arr;
	int         mismatches, tests_run, cycles, n_irq, n_slp, n_wak;
	logic [7:0] rq [$];
	sfs_sector_flash_sequencer #(.ERASE_CYCLES(ERASE_N), .PROG_SECTOR_CYCLES(PROG_N)) dut_u (.mclk(mclk),
		.resetn(resetn), .req(req), .req_ready(req_ready), .busy(busy), .done(done), .reject(reject),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.flash_error_irq_enable(irq_en), .flash_error_irq(irq), .ext_selected(ext_sel),
		.ext_flash_sleep_cmd(slp), .ext_flash_wake_cmd(wak), .arr(arr), .array_rdata(array_rdata),
		.array_rd_err(array_rd_err));
	sfs_array_model mdl_u (.mclk(mclk), .arr(arr), .bad(bad), .array_rdata(array_rdata),
		.array_rd_err(array_rd_err));
	// Clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Read capture, pulse counts and watchdog
	always @(posedge mclk) begin
		cycles++;
		if (rd_valid === 1'b1) rq.push_back(rd_data);
		n_irq += int'(irq === 1'b1);
		n_slp += int'(slp === 1'b1);
		n_wak += int'(wak === 1'b1);
		if (cycles == 3000) begin
			mismatches++;
			final_report();
		end
	end
	function automatic logic [7:0] pat(int i);
		return 8'h3C ^ 8'(i);
	endfunction
	task automatic final_report();
		$display("mismatches %0d of %0d checks", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(logic [19:0] got, logic [19:0] exp, string what);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// Hold a request until an edge sees it taken
	task automatic send(sfs_op_t op, logic [18:0] a, logic [19:0] l, logic e, logic s);
		req = '{1'b1, op, a, l, e, s};
		do @(posedge mclk); while (req_ready !== 1'b1);
		#1 req.valid = 1'b0;
	endtask
	task automatic fin(output int n, output logic rj);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (done !== 1'b1 && reject !== 1'b1);
		rj = reject;
		#1;
	endtask
	task automatic rd(logic [18:0] a, logic [19:0] l, logic blank);
		int n;
		logic rj;
		rq.delete();
		send(OP_READ, a, l, 1'b0, 1'b0);
		fin(n, rj);
		chk(20'(rq.size()), l, "read count");
		foreach (rq[i]) chk(20'(rq[i]), 20'(blank ? 8'hFF : pat(i)), "read byte");
	endtask
	task automatic rej(sfs_op_t op, logic [18:0] a, logic [19:0] l);
		int n;
		logic rj;
		send(op, a, l, 1'b0, 1'b0);
		fin(n, rj);
		chk(20'(rj), 20'h1, "refusal");
	endtask
	task automatic pwr(logic e, logic s, int exp);
		int n, a, b;
		logic rj;
		a = n_slp;
		b = n_wak;
		send(OP_SELECT, 19'h0, 20'h0, e, s);
		fin(n, rj);
		chk(20'(ext_sel), 20'(e), "target");
		chk(20'(arr.ext), 20'(e), "array target");
		send(OP_SLEEP, 19'h0, 20'h0, 1'b0, 1'b0);
		fin(n, rj);
		send(OP_WAKE, 19'h0, 20'h0, 1'b0, 1'b0);
		fin(n, rj);
		chk(20'(n_slp - a), 20'(exp), "sleep pulses");
		chk(20'(n_wak - b), 20'(exp), "wake pulses");
	endtask
	task automatic sc_program();
		int n;
		logic rj;
		send(OP_PROGRAM, 19'h08010, 20'h10, 1'b0, 1'b0);
		wr_valid = 1'b1;
		for (int i = 0; i < 16; i++) begin
			wr_data = pat(i);
			do @(posedge mclk); while (wr_ready !== 1'b1);
			#1;
		end
		wr_valid = 1'b0;
		fin(n, rj);
		chk(20'(rj), 20'h0, "program done");
		chk(20'(n), 20'(3 + PROG_N / PW_PER_SECTOR), "pageword hold");
		rd(19'h08010, 20'h10, 1'b0);
		rej(OP_PROGRAM, 19'h08018, 20'h10);
		rej(OP_PROGRAM, 19'h08010, 20'h08);
		rej(OP_READ, 19'h7FFFF, 20'h2);
		rej(OP_NOP, 19'h00000, 20'h0);
	endtask
	task automatic sc_erase();
		int n;
		logic rj;
		send(OP_ERASE, 19'h08123, 20'h0, 1'b0, 1'b0);
		fin(n, rj);
		chk(20'(n >= ERASE_N && n <= ERASE_N + 3), 20'h1, "erase time");
		rd(19'h08010, 20'h10, 1'b1);
		rq.delete();
		send(OP_ERASE, 19'h00000, 20'h0, 1'b0, 1'b0);
		// One edge between requests so req changes once per step
		@(posedge mclk);
		#1;
		chk(20'(busy), 20'h1, "busy in erase");
		send(OP_READ, 19'h00007, 20'h1, 1'b0, 1'b0);
		fin(n, rj);
		chk(20'(rq.size()), 20'h1, "held read");
		chk(20'(n), 20'h3, "held read time");
		chk(20'(rq[0]), 20'hFF, "sector zero blank");
	endtask
	task automatic sc_irq();
		int a;
		bad = 1'b1;
		irq_en = 1'b1;
		a = n_irq;
		rd(19'h00021, 20'h2, 1'b1);
		chk(20'(n_irq - a), 20'h2, "irq enabled");
		irq_en = 1'b0;
		rd(19'h00021, 20'h2, 1'b1);
		chk(20'(n_irq - a), 20'h2, "irq masked");
		bad = 1'b0;
	endtask
	// Main sequence
	initial begin
		req = '0;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		irq_en = 1'b0;
		bad = 1'b0;
		resetn = 1'b0;
		repeat (3) @(posedge mclk);
		#1 resetn = 1'b1;
		@(posedge mclk);
		#1;
		chk(20'(req_ready), 20'h1, "ready after reset");
		pwr(1'b1, 1'b0, 0);
		pwr(1'b0, 1'b1, 0);
		pwr(1'b1, 1'b1, 1);
		pwr(1'b0, 1'b0, 0);
		rd(19'h12345, 20'h4, 1'b1);
		sc_program();
		sc_erase();
		sc_irq();
		final_report();
	end
endmodule
